// file: src/fps_pkg.sv
// Purpose: Shared constants and types of the flash protect/security control
// Assumes: 32-bit register words, byte offsets on an 8-bit register address
// Notes:   Structs carry the register port and the command paths
package fps_pkg;

  localparam int          FPS_BLOCKS       = 4;
  localparam int          FPS_ADDR_W       = 8;
  localparam int          FPS_DATA_W       = 32;

  // Register byte offsets
  localparam logic [7:0]  FPS_OFS_SECURITY = 8'h10;
  localparam logic [7:0]  FPS_OFS_READY    = 8'h20;
  localparam logic [7:0]  FPS_OFS_PSTATUS  = 8'h30;
  localparam logic [7:0]  FPS_OFS_PMASK    = 8'h38;

  // Field positions
  localparam int          FPS_BIT_SECURITY = 0;
  localparam int          FPS_BIT_READY    = 0;

  // Reset values
  localparam logic        FPS_RST_SECURITY = 1'b1;
  localparam logic [3:0]  FPS_RST_MASK     = 4'hf;
  localparam logic        FPS_RST_READY    = 1'b1;

  // Unlock key and the window that follows it, in clock cycles
  localparam logic [31:0] FPS_UNLOCK_KEY   = 32'ha74a9d23;
  localparam logic [4:0]  FPS_KEY_WINDOW   = 5'h10;

  typedef enum logic [2:0] {
    FPS_CMD_PAGE_PROGRAM,
    FPS_CMD_BLOCK_ERASE,
    FPS_CMD_CHIP_ERASE,
    FPS_CMD_PROTECT_PROGRAM,
    FPS_CMD_PROTECT_ERASE
  } fps_cmd_type;

  typedef enum logic [1:0] {
    FPS_ST_READY,
    FPS_ST_BUSY,
    FPS_ST_FAILED
  } fps_state_type;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [FPS_ADDR_W-1:0] addr;
    logic [FPS_DATA_W-1:0] wdata;
  } fps_bus_req_type;

  typedef struct packed {
    logic        valid;
    fps_cmd_type code;
    logic [1:0]  block;
  } fps_cmd_req_type;

endpackage : fps_pkg

// file: src/fps_flash_protect.sv
// Purpose: Block protect bits, protect mask, security bit and ready/busy
//          gating of flash commands toward the automatic-operation engine
// Assumes: Register port, command port and engine results all on ref_clk
// Notes:   Protect and security bits sit in the power-on domain only
//
// How it works
// - Each block has a protect bit; set bit blocks write and erase.
// - Protect erase command clears protect bits, cancelling protection.
// - Protect bits program singly, erase only all four together.
// - Mask bit at zero lifts a block's protection, stored bit untouched.
// - System reset sets all four mask bits back to one.
// - Stored protect bits never change with the mask setting.
// - Chip erase is refused while any mask bit is zero.
// - Secured only when security bit and all protect bits are one.
// - Secured state leaves CPU reads of the flash untouched.
// - Secured state disables JTAG, serial wire and trace debug.
// - Secured: commands refused; protect erase becomes full chip erase.
// - Secured and masked: only block erase and page program pass.
// - Security bit is one after power-on reset, kept over others.
// - Ready bit is zero during an operation, one after; then next.
// - A failed operation keeps the ready bit low until reset.
// - Command while busy is dropped, later commands may be refused.
// - Each stored protect bit is readable in the status register.
// - Status bits 3..0 show blocks 3..0, upper bits read zero.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps

module fps_flash_protect
  import fps_pkg::*;
#(
  parameter logic [3:0] PROTECT_INIT = 4'h0
)(
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            power_on_reset_a,
  input  wire fps_bus_req_type bus_req,
  output      logic [31:0]     rd_data,
  input  wire fps_cmd_req_type cmd_req,
  output      fps_cmd_req_type op_req,
  input  wire logic            op_done,
  input  wire logic            op_fail,
  output      logic            cmd_rejected,
  output      logic            ready_not_busy,
  output      logic            secured,
  output      logic            debug_disable,
  output      logic [3:0]      block_write_enable
);

  // Values that survive a system reset
  typedef struct packed {
    logic       security_enable_bit;
    logic [3:0] block_protected_flag;
  } fps_keep_type;

  typedef struct packed {
    fps_state_type   st;
    logic [3:0]      block_protect_unmask;
    logic            key_armed;
    logic            key_to_sec;
    logic [4:0]      key_count;
    fps_cmd_type     run_code;
    logic [1:0]      run_block;
    logic            run_clears_prot;
    logic            hung;
    fps_cmd_req_type op_req;
    logic            cmd_rejected;
    logic [31:0]     rd_data;
    logic            ready;
    logic            secured;
    logic            debug_disable;
    logic [3:0]      write_enable;
  } fps_state_struct_type;

  localparam fps_state_struct_type FPS_STATE_RESET = '{
    st:                   FPS_ST_READY,
    block_protect_unmask: FPS_RST_MASK,
    key_armed:            1'b0,
    key_to_sec:           1'b0,
    key_count:            5'h00,
    run_code:             FPS_CMD_PAGE_PROGRAM,
    run_block:            2'h0,
    run_clears_prot:      1'b0,
    hung:                 1'b0,
    op_req:               '0,
    cmd_rejected:         1'b0,
    rd_data:              32'h0000_0000,
    ready:                FPS_RST_READY,
    secured:              1'b0,
    debug_disable:        1'b0,
    write_enable:         4'h0
  };

  fps_state_struct_type state_reg;
  fps_state_struct_type state_next;
  fps_keep_type         keep_reg;
  fps_keep_type         keep_next;

  logic                 wr_sec;
  logic                 wr_mask;
  logic                 is_key;
  logic                 key_live;
  logic                 is_secured;
  logic                 any_masked;
  logic [3:0]           eff_protect;
  logic                 accept;
  fps_cmd_type          start_code;
  logic                 start_clears;

  always_comb
  begin
    state_next = state_reg;
    keep_next  = keep_reg;
    wr_sec     = bus_req.wr && (bus_req.addr == FPS_OFS_SECURITY);
    wr_mask    = bus_req.wr && (bus_req.addr == FPS_OFS_PMASK);
    is_key     = (bus_req.wdata == FPS_UNLOCK_KEY);
    key_live   = state_reg.key_armed && (state_reg.key_count != 5'h00);
    any_masked = ~&state_reg.block_protect_unmask;
    eff_protect  = keep_reg.block_protected_flag
                   & state_reg.block_protect_unmask;
    is_secured   = keep_reg.security_enable_bit
                   && (&keep_reg.block_protected_flag);
    accept       = 1'b0;
    start_code   = cmd_req.code;
    start_clears = 1'b0;

    state_next.op_req.valid  = 1'b0;
    state_next.cmd_rejected  = 1'b0;

    // Unlock window runs down once per cycle
    if (key_live)
    begin
      state_next.key_count = state_reg.key_count - 5'h01;
    end
    else
    begin
      state_next.key_armed = 1'b0;
    end

    // Data accepted only right after a key
    if (wr_sec || wr_mask)
    begin
      if (key_live && (state_reg.key_to_sec == wr_sec))
      begin
        state_next.key_armed = 1'b0;
        if (wr_sec)
        begin
          keep_next.security_enable_bit = bus_req.wdata[FPS_BIT_SECURITY];
        end
        else
        begin
          state_next.block_protect_unmask = bus_req.wdata[3:0];
        end
      end
      else if (is_key)
      begin
        state_next.key_armed  = 1'b1;
        state_next.key_to_sec = wr_sec;
        state_next.key_count  = FPS_KEY_WINDOW;
      end
      else
      begin
        state_next.key_armed = 1'b0;
      end
    end

    // Command acceptance
    if (cmd_req.valid)
    begin
      // Busy, failed or hung drops the command
      if ((state_reg.st != FPS_ST_READY) || state_reg.hung)
      begin
        // A command lost mid-operation may leave the sequence half taken
        if (state_reg.st == FPS_ST_BUSY)
        begin
          state_next.hung = 1'b1;
        end
      end
      else if (is_secured && !any_masked)
      begin
        if (cmd_req.code == FPS_CMD_PROTECT_ERASE)
        begin
          accept       = 1'b1;
          start_code   = FPS_CMD_CHIP_ERASE;
          start_clears = 1'b1;
        end
      end
      else if (is_secured)
      begin
        if ((cmd_req.code == FPS_CMD_PAGE_PROGRAM)
            || (cmd_req.code == FPS_CMD_BLOCK_ERASE))
        begin
          accept = !eff_protect[cmd_req.block];
        end
      end
      else
      begin
        unique case (cmd_req.code)
          FPS_CMD_PAGE_PROGRAM,
          FPS_CMD_BLOCK_ERASE:
          begin
            // Protected block refuses write and erase
            accept = !eff_protect[cmd_req.block];
          end
          FPS_CMD_CHIP_ERASE:
          begin
            // No chip erase with mask active
            accept = !any_masked;
          end
          FPS_CMD_PROTECT_PROGRAM:
          begin
            accept = 1'b1;
          end
          FPS_CMD_PROTECT_ERASE:
          begin
            accept       = 1'b1;
            start_clears = 1'b1;
          end
          // Unused command codes start nothing
          default:
          begin
            accept = 1'b0;
          end
        endcase
      end
      state_next.cmd_rejected = !accept;
    end

    if (accept)
    begin
      state_next.st              = FPS_ST_BUSY;
      state_next.run_code        = start_code;
      state_next.run_block       = cmd_req.block;
      state_next.run_clears_prot = start_clears;
      state_next.op_req.valid    = 1'b1;
      state_next.op_req.code     = start_code;
      state_next.op_req.block    = cmd_req.block;
    end
    else if ((state_reg.st == FPS_ST_BUSY) && op_done)
    begin
      if (op_fail)
      begin
        state_next.st = FPS_ST_FAILED;
      end
      else
      begin
        state_next.st = FPS_ST_READY;
        // Program one bit, erase all four
        if (state_reg.run_code == FPS_CMD_PROTECT_PROGRAM)
        begin
          keep_next.block_protected_flag[state_reg.run_block] = 1'b1;
        end
        if (state_reg.run_clears_prot)
        begin
          keep_next.block_protected_flag = 4'h0;
        end
      end
    end

    state_next.ready = (state_next.st == FPS_ST_READY);
    // Reads never gated
    // Only debug and command entry close while secured; flash reads have
    // no gate here, so the CPU keeps running from the array
    // Debug off while secured
    state_next.secured       = keep_next.security_enable_bit
                               && (&keep_next.block_protected_flag);
    state_next.debug_disable = state_next.secured;
    state_next.write_enable  = ~(keep_next.block_protected_flag
                                 & state_next.block_protect_unmask);

    // Read data, one cycle after the strobe
    state_next.rd_data = 32'h0000_0000;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        FPS_OFS_SECURITY:
          state_next.rd_data[FPS_BIT_SECURITY] = keep_reg.security_enable_bit;
        FPS_OFS_READY:
          state_next.rd_data[FPS_BIT_READY] = state_reg.ready;
        FPS_OFS_PSTATUS:
          state_next.rd_data[3:0] = keep_reg.block_protected_flag;
        FPS_OFS_PMASK:
          state_next.rd_data[3:0] = state_reg.block_protect_unmask;
        default:
          state_next.rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst or posedge power_on_reset_a)
  begin
    if (rst || power_on_reset_a)
    begin
      state_reg <= FPS_STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Stand-in for the nonvolatile cells: only power-on reloads them
  // Security bit set at power-on only
  // Protect bits untouched by system reset
  always_ff @(posedge ref_clk or posedge power_on_reset_a)
  begin
    if (power_on_reset_a)
    begin
      keep_reg.security_enable_bit  <= FPS_RST_SECURITY;
      keep_reg.block_protected_flag <= PROTECT_INIT;
    end
    else
    begin
      keep_reg <= keep_next;
    end
  end

  assign rd_data            = state_reg.rd_data;
  assign op_req             = state_reg.op_req;
  assign cmd_rejected       = state_reg.cmd_rejected;
  assign ready_not_busy     = state_reg.ready;
  assign secured            = state_reg.secured;
  assign debug_disable      = state_reg.debug_disable;
  assign block_write_enable = state_reg.write_enable;

endmodule : fps_flash_protect

// file: tb/fps_flash_protect_props.sv
// Purpose: Port-level checks of the flash protect/security control
// Assumes: One clock domain, either reset disables the checks
// Notes:   Bound to every fps_flash_protect instance
`timescale 1ns/10ps

module fps_flash_protect_props
  import fps_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            rst,
  input wire logic            power_on_reset_a,
  input wire fps_bus_req_type bus_req,
  input wire logic [31:0]     rd_data,
  input wire fps_cmd_req_type cmd_req,
  input wire fps_cmd_req_type op_req,
  input wire logic            op_done,
  input wire logic            op_fail,
  input wire logic            cmd_rejected,
  input wire logic            ready_not_busy,
  input wire logic            secured,
  input wire logic            debug_disable,
  input wire logic [3:0]      block_write_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || power_on_reset_a);

  property p_dbg; debug_disable == secured; endproperty
  a_dbg: assert property (p_dbg) else $error("debug gate off");
  property p_rdz; !bus_req.rd |=> rd_data == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("stale read data");
  property p_rdy;
    bus_req.rd && bus_req.addr == FPS_OFS_READY
      |=> rd_data == {31'h0, $past(ready_not_busy)};
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready read wrong");
  property p_psr;
    bus_req.rd && bus_req.addr == FPS_OFS_PSTATUS |=> rd_data[31:4] == 28'h0;
  endproperty
  a_psr: assert property (p_psr) else $error("status upper bits");
  property p_srd;
    bus_req.rd && bus_req.addr == FPS_OFS_SECURITY |=> rd_data[31:1] == 31'h0;
  endproperty
  a_srd: assert property (p_srd) else $error("security bits");
  property p_start;
    op_req.valid |-> !ready_not_busy ##1 !op_req.valid;
  endproperty
  a_start: assert property (p_start) else $error("not busy");
  property p_done; op_done && !op_fail |=> ready_not_busy; endproperty
  a_done: assert property (p_done) else $error("ready not back");
  property p_fail; op_done && op_fail |=> !ready_not_busy [*8]; endproperty
  a_fail: assert property (p_fail) else $error("ready rose");
  property p_chip;
    secured && ready_not_busy && cmd_req.valid
      && block_write_enable == 4'h0
      && cmd_req.code == FPS_CMD_PROTECT_ERASE
      |=> op_req.valid && op_req.code == FPS_CMD_CHIP_ERASE;
  endproperty
  a_chip: assert property (p_chip) else $error("no chip erase");
endmodule : fps_flash_protect_props

bind fps_flash_protect fps_flash_protect_props i_props (
  .ref_clk(ref_clk), .rst(rst), .power_on_reset_a(power_on_reset_a),
  .bus_req(bus_req), .rd_data(rd_data), .cmd_req(cmd_req), .op_req(op_req),
  .op_done(op_done), .op_fail(op_fail), .cmd_rejected(cmd_rejected),
  .ready_not_busy(ready_not_busy), .secured(secured),
  .debug_disable(debug_disable), .block_write_enable(block_write_enable));

// file: tb/fps_engine_model.sv
// Purpose: Automatic-operation engine answering started commands
// Assumes: Start pulses arrive only while the engine is idle
// Notes:   Failure is reported only when the bench asks for it
`timescale 1ns/10ps

module fps_engine_model
  import fps_pkg::*;
#(
  parameter int LAT = 4
)(
  input  wire logic            ref_clk,
  input  wire logic            rst_any,
  input  wire fps_cmd_req_type op_req,
  input  wire logic            fail_next,
  output      logic            op_done,
  output      logic            op_fail
);
  int cnt;

  // done after LAT, fail on demand
  always_ff @(posedge ref_clk or posedge rst_any)
    if (rst_any)
    begin
      cnt     <= 0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
    end
    else
    begin
      op_done <= (cnt == 1);
      op_fail <= (cnt == 1) && fail_next;
      cnt     <= op_req.valid ? LAT : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule : fps_engine_model

// file: tb/flash_protect_security_ctrl_test.sv
// Purpose: Self-checking bench of the flash protect/security control
// Assumes: Bench plays the CPU, engine model answers started commands
// Notes:   Power-on protect content is the default of all zero
`timescale 1ns/10ps

module flash_protect_security_ctrl_test;
  import fps_pkg::*;
  logic            ref_clk, rst, por, rst_any, fail_next;
  fps_bus_req_type bq;
  fps_cmd_req_type cq, op_req;
  logic [31:0]     rd_data;
  logic            op_done, op_fail, rej, rdy, sec, dbg;
  logic [3:0]      bwe;
  int              n_mismatch, n_compared;

  assign rst_any = rst | por;
  fps_flash_protect i_dut (.ref_clk(ref_clk), .rst(rst),
    .power_on_reset_a(por), .bus_req(bq), .rd_data(rd_data), .cmd_req(cq),
    .op_req(op_req), .op_done(op_done), .op_fail(op_fail),
    .cmd_rejected(rej), .ready_not_busy(rdy), .secured(sec),
    .debug_disable(dbg), .block_write_enable(bwe));
  fps_engine_model i_eng (.ref_clk(ref_clk), .rst_any(rst_any),
    .op_req(op_req), .fail_next(fail_next), .op_done(op_done),
    .op_fail(op_fail));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task test_done;
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) bq <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) bq <= '0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk) bq <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk) bq <= '0;
    #1 chk(rd_data, exp);
  endtask : rd

  // Expect {started, rejected} in the cycle after the command is taken
  task cmd(input fps_cmd_type c, input logic [1:0] b, input logic [1:0] e);
    @(posedge ref_clk) cq <= '{1'b1, c, b};
    @(posedge ref_clk) cq <= '0;
    #1 chk({op_req.valid, rej}, e);
  endtask : cmd

  task wait_rdy;
    int i;
    for (i = 0; i < 30 && rdy !== 1'b1; i++) @(posedge ref_clk) #1;
    chk(rdy, 1'b1);
  endtask : wait_rdy

  task t_reset;
    rd(FPS_OFS_READY, 32'h1);
    rd(FPS_OFS_SECURITY, 32'h1);
    rd(FPS_OFS_PMASK, 32'hf);
    rd(FPS_OFS_PSTATUS, 32'h0);
    wr(FPS_OFS_READY, 32'h0);
    rd(FPS_OFS_READY, 32'h1);
    rd(8'h44, 32'h0);
  endtask : t_reset

  task t_protect;
    cmd(FPS_CMD_PROTECT_PROGRAM, 2'h2, 2'b10);
    wait_rdy();
    rd(FPS_OFS_PSTATUS, 32'h4);
    chk(bwe, 4'hb);
    cmd(FPS_CMD_PAGE_PROGRAM, 2'h2, 2'b01);
    cmd(FPS_CMD_BLOCK_ERASE, 2'h1, 2'b10);
    wait_rdy();
    wr(FPS_OFS_PMASK, FPS_UNLOCK_KEY);
    wr(FPS_OFS_PMASK, 32'h0000000b);
    rd(FPS_OFS_PMASK, 32'hb);
    rd(FPS_OFS_PSTATUS, 32'h4);
    chk(bwe, 4'hf);
    cmd(FPS_CMD_CHIP_ERASE, 2'h0, 2'b01);
    wr(FPS_OFS_PMASK, 32'hf);
    rd(FPS_OFS_PMASK, 32'hb);
    wr(FPS_OFS_PMASK, FPS_UNLOCK_KEY);
    repeat (17) @(posedge ref_clk);
    wr(FPS_OFS_PMASK, 32'hf);
    rd(FPS_OFS_PMASK, 32'hb);
  endtask : t_protect

  task t_secure;
    int b;
    chk(sec, 1'b0);
    for (b = 0; b < 4; b++)
      if (b != 2)
      begin
        cmd(FPS_CMD_PROTECT_PROGRAM, b[1:0], 2'b10);
        wait_rdy();
      end
    chk(sec, 1'b1);
    @(posedge ref_clk) rst <= 1'b1;
    @(posedge ref_clk) rst <= 1'b0;
    rd(FPS_OFS_PMASK, 32'hf);
    rd(FPS_OFS_SECURITY, 32'h1);
    chk({sec, dbg}, 2'b11);
    cmd(FPS_CMD_PAGE_PROGRAM, 2'h0, 2'b01);
    wr(FPS_OFS_PMASK, FPS_UNLOCK_KEY);
    wr(FPS_OFS_PMASK, 32'h0000000e);
    rd(FPS_OFS_PMASK, 32'he);
    cmd(FPS_CMD_PROTECT_ERASE, 2'h0, 2'b01);
    cmd(FPS_CMD_PAGE_PROGRAM, 2'h1, 2'b01);
    cmd(FPS_CMD_BLOCK_ERASE, 2'h0, 2'b10);
    wait_rdy();
    rd(FPS_OFS_PSTATUS, 32'hf);
    wr(FPS_OFS_PMASK, FPS_UNLOCK_KEY);
    wr(FPS_OFS_PMASK, 32'h0000000f);
    rd(FPS_OFS_PMASK, 32'hf);
    cmd(FPS_CMD_PROTECT_ERASE, 2'h2, 2'b10);
    chk(op_req.code, FPS_CMD_CHIP_ERASE);
    wait_rdy();
    rd(FPS_OFS_PSTATUS, 32'h0);
    chk({sec, dbg}, 2'b00);
    wr(FPS_OFS_SECURITY, FPS_UNLOCK_KEY);
    wr(FPS_OFS_SECURITY, 32'h0);
    rd(FPS_OFS_SECURITY, 32'h0);
  endtask : t_secure

  task t_fail;
    @(posedge ref_clk) fail_next <= 1'b1;
    cmd(FPS_CMD_PAGE_PROGRAM, 2'h2, 2'b10);
    repeat (12) @(posedge ref_clk);
    rd(FPS_OFS_READY, 32'h0);
    @(posedge ref_clk) por <= 1'b1;
    fail_next <= 1'b0;
    @(posedge ref_clk) por <= 1'b0;
    rd(FPS_OFS_READY, 32'h1);
    rd(FPS_OFS_SECURITY, 32'h1);
    cmd(FPS_CMD_BLOCK_ERASE, 2'h1, 2'b10);
    cmd(FPS_CMD_BLOCK_ERASE, 2'h2, 2'b01);
    wait_rdy();
    cmd(FPS_CMD_BLOCK_ERASE, 2'h1, 2'b01);
    // Stuck command state is cleared by a system reset; the bench holds rst for 500 ns
    @(posedge ref_clk) rst <= 1'b1;
    repeat (25) @(posedge ref_clk);
    rst <= 1'b0;
    cmd(FPS_CMD_BLOCK_ERASE, 2'h1, 2'b10);
    wait_rdy();
  endtask : t_fail

  initial
  begin
    bq = '0;
    cq = '0;
    rst = 1'b1;
    por = 1'b1;
    fail_next = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_reset();
    t_protect();
    t_secure();
    t_fail();
    test_done();
  end

  initial
  begin
    #100us;
    n_mismatch++;
    test_done();
  end
endmodule : flash_protect_security_ctrl_test
